// ### jfcs_consts.svh
// constants for the fuse check sequencer
// assumes inclusion by bare name from any design file
`ifndef JFCS_CONSTS_SVH
`define JFCS_CONSTS_SVH
`define JFCS_SYNC_STAGES 2
`define JFCS_RISE_EXIT_COUNT 2'h2
`define JFCS_RISE_RESET 2'h0
`endif

// ### jfcs_pkg.sv
// types for the fuse check sequencer
// assumes nothing beyond a SystemVerilog compiler
package jfcs_pkg;
    typedef enum logic [2:0] {
        JFCS_IDLE = 3'b001,
        JFCS_ACTIVE = 3'b010,
        JFCS_DONE = 3'b100
    } jfcs_state_t;
    typedef struct packed {
        logic active;
        logic sense_en;
    } jfcs_status_t;
endpackage

// ### jfcs_sync.sv
// two flip-flop synchroniser for the mode select pin
// assumes asynchronous active-low power-on reset; pin idles high
`timescale 1ns/100ps
`default_nettype none
module jfcs_sync (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // pin in, synchronised out
    input wire logic pin_i,
    output logic pin_sync_o
);
    logic meta_reg;
    logic sync_reg;

    // reset to high: idle level of the pin
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync_o = sync_reg;
endmodule
`default_nettype wire

// ### jfcs_sequencer.sv
// fuse continuity check sequencer on the test access port
// assumes reset_n_i is power-on reset only; mode select pin is asynchronous
//
// Summary of operation
// - run fuse continuity check on first access
// - enter check on first mode-select falling edge
// - enter check if pin low at power-up
// - leave check on second rising edge
// - stay disabled until next power-on reset
// - sense current only when active and pin low
`timescale 1ns/100ps
`default_nettype none
`include "jfcs_consts.svh"
module jfcs_sequencer
    import jfcs_pkg::*;
#(
    parameter bit FUSE_ON_DATA_PIN = 1'b1
) (
    // clock and power-on reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // probe pin
    input wire logic mode_sel_i,
    // fuse check outputs
    output logic check_active_o,
    output logic fuse_sense_current_en_o
);
    // ****************************************
    // pin synchronisation and edge detection
    // ****************************************
    logic mode_sync;
    logic mode_prev_reg;
    logic first_cycle_reg;
    logic [1:0] settle_reg;
    logic fall_evt;
    logic rise_evt;

    jfcs_sync u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(mode_sel_i),
        .pin_sync_o(mode_sync)
    );

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_prev_reg <= 1'b1;
        end else begin
            mode_prev_reg <= mode_sync;
        end
    end

    // synchroniser shows its reset level for two edges after release;
    // flag the first edge at which it carries a real pin sample
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_reg <= 2'h3;
            first_cycle_reg <= 1'b0;
        end else begin
            settle_reg <= {settle_reg[0], 1'b0};
            first_cycle_reg <= settle_reg[1] & ~settle_reg[0];
        end
    end

    assign fall_evt = mode_prev_reg & ~mode_sync;
    assign rise_evt = ~mode_prev_reg & mode_sync;

    // ****************************************
    // check mode state machine
    // ****************************************
    jfcs_state_t state_reg;
    jfcs_state_t state_next;
    logic [1:0] rise_cnt_reg;
    logic [1:0] rise_cnt_next;
    logic arm_req;

    // low at power-up shows as low on the first synchronised sample
    assign arm_req = FUSE_ON_DATA_PIN & (fall_evt | (first_cycle_reg & ~mode_sync));

    always_comb begin
        state_next = state_reg;
        rise_cnt_next = rise_cnt_reg;
        case (state_reg)
            JFCS_IDLE: begin
                if (arm_req) begin
                    state_next = JFCS_ACTIVE;
                    rise_cnt_next = `JFCS_RISE_RESET;
                end
            end
            JFCS_ACTIVE: begin
                if (rise_evt) begin
                    rise_cnt_next = rise_cnt_reg + 2'h1;
                    if (rise_cnt_reg + 2'h1 == `JFCS_RISE_EXIT_COUNT) begin
                        state_next = JFCS_DONE;
                    end
                end
            end
            JFCS_DONE: begin
                state_next = JFCS_DONE;
            end
            default: begin
                state_next = JFCS_DONE;
            end
        endcase
    end

    // only power-on reset clears this; no soft reset input exists
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= JFCS_IDLE;
            rise_cnt_reg <= `JFCS_RISE_RESET;
        end else begin
            state_reg <= state_next;
            rise_cnt_reg <= rise_cnt_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    jfcs_status_t status_next;

    // gate on pin low; a probe holding the pin high draws no current
    always_comb begin
        status_next.active = (state_next == JFCS_ACTIVE);
        status_next.sense_en = (state_next == JFCS_ACTIVE) & ~mode_sync;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            check_active_o <= 1'b0;
            fuse_sense_current_en_o <= 1'b0;
        end else begin
            check_active_o <= status_next.active;
            fuse_sense_current_en_o <= status_next.sense_en;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_second_rise;
        rise_evt && state_reg == JFCS_ACTIVE && rise_cnt_reg == 2'h1;
    endsequence

    a_sense_gated: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        fuse_sense_current_en_o |-> check_active_o && !$past(mode_sync))
        else $error("sense current enabled outside active low phase");

    a_arm_on_fall: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_IDLE && fall_evt) |=> check_active_o)
        else $error("falling edge did not arm check");

    a_arm_low_start: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (first_cycle_reg && !mode_sync) |=> check_active_o && fuse_sense_current_en_o)
        else $error("low at power-up did not arm check");

    a_exit_second: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_second_rise |=> !check_active_o && state_reg == JFCS_DONE)
        else $error("second rising edge did not end check");

    a_first_rise_stays: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (rise_evt && state_reg == JFCS_ACTIVE && rise_cnt_reg == 2'h0) |=> check_active_o)
        else $error("first rising edge ended check");

    a_done_sticky: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state_reg == JFCS_DONE |=> state_reg == JFCS_DONE && !check_active_o
            && !fuse_sense_current_en_o)
        else $error("check re-armed without power-on reset");

    a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_IDLE && !arm_req) |=> !check_active_o)
        else $error("check active without arming event");

    a_reset_clears: assert property (@(posedge core_clk_i)
        $rose(reset_n_i) |-> state_reg == JFCS_IDLE && rise_cnt_reg == 2'h0 && !check_active_o)
        else $error("power-on reset did not clear state");

    sequence s_active_pin_low;
        state_next == JFCS_ACTIVE && !mode_sync;
    endsequence

    sequence s_pin_edge;
        fall_evt || rise_evt;
    endsequence

    a_sense_on_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_active_pin_low |=> fuse_sense_current_en_o)
        else $error("sense current missing while active and pin low");

    a_sense_off_high: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        mode_sync |=> !fuse_sense_current_en_o)
        else $error("sense current on with pin high");

    a_sense_off_idle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state_next != JFCS_ACTIVE |=> !fuse_sense_current_en_o)
        else $error("sense current on outside check mode");

    a_enter_state: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_IDLE && arm_req)
            |=> state_reg == JFCS_ACTIVE && rise_cnt_reg == 2'h0)
        else $error("arming did not start a fresh edge count");

    a_idle_no_arm: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_IDLE && !arm_req) |=> state_reg == JFCS_IDLE)
        else $error("idle state left without arming event");

    a_fall_ignored: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_ACTIVE && fall_evt) |=> check_active_o && $stable(rise_cnt_reg))
        else $error("falling edge disturbed active check");

    a_count_holds: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_ACTIVE && !rise_evt) |=> $stable(rise_cnt_reg))
        else $error("rise count moved without rising edge");

    a_leave_two: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_ACTIVE && !(rise_evt && rise_cnt_reg == 2'h1))
            |=> state_reg == JFCS_ACTIVE)
        else $error("check left before second rising edge");

    a_done_deaf: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_reg == JFCS_DONE) ##0 s_pin_edge |=> !check_active_o && !fuse_sense_current_en_o)
        else $error("pin edge re-armed finished check");

    a_first_sample_once: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        first_cycle_reg |=> !first_cycle_reg)
        else $error("power-up sample flag held too long");
endmodule
`default_nettype wire

// ### jfcs_probe.sv
// debug probe model that drives the mode select pin
// assumes the bench requests pin levels at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module jfcs_probe (
    // request from bench
    input wire logic drive_low_i,
    // pin to device
    output logic mode_sel_o
);
    // ********************
    // pin driver
    // ********************
    // idles high so the check never arms by accident
    always_comb mode_sel_o = ~drive_low_i;
endmodule
`default_nettype wire

// ### tb_jfcs.sv
// self-checking bench for the fuse check sequencer
// assumes the probe model file is compiled before this one
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic drive_low = 1'b0;
    wire logic mode_sel;
    wire logic active;
    wire logic sense;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    jfcs_probe u_jfcs_probe (.drive_low_i(drive_low), .mode_sel_o(mode_sel));
    jfcs_sequencer u_jfcs_sequencer (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .mode_sel_i(mode_sel),
        .check_active_o(active),
        .fuse_sense_current_en_o(sense)
    );
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // ********************
    // shared tasks
    // ********************
    task automatic check(input logic [1:0] exp);
        comparisons++;
        if ({active, sense} !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, {active, sense}, exp);
        end
    endtask
    // five cycles leaves margin over the three-edge answer
    task automatic step(input logic low, input logic [1:0] exp);
        @(negedge core_clk_i);
        drive_low = low;
        repeat (5) @(negedge core_clk_i);
        check(exp);
    endtask
    task automatic power_on(input logic low);
        @(negedge core_clk_i);
        reset_n_i = 1'b0;
        drive_low = low;
        repeat (6) @(negedge core_clk_i);
        check(2'h0);
        reset_n_i = 1'b1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic test_edge_entry();
        power_on(1'b0);
        step(1'b0, 2'h0);
        step(1'b1, 2'h3);
        step(1'b0, 2'h2);
        step(1'b1, 2'h3);
        step(1'b0, 2'h0);
        step(1'b1, 2'h0);
        step(1'b0, 2'h0);
    endtask
    task automatic test_low_at_power();
        power_on(1'b1);
        repeat (5) @(negedge core_clk_i);
        check(2'h3);
        step(1'b0, 2'h2);
        step(1'b1, 2'h3);
        step(1'b0, 2'h0);
    endtask
    task automatic test_rearm();
        power_on(1'b0);
        step(1'b1, 2'h3);
        power_on(1'b0);
        step(1'b0, 2'h0);
        step(1'b1, 2'h3);
    endtask
    // ********************
    // main sequence and timeout
    // ********************
    initial begin
        test_edge_entry();
        test_low_at_power();
        test_rearm();
        finish_test();
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
